// ---- core/test_mode_pkg.sv ----
// Functional notes
// [R1] Selection is recognised only after power_good has been high for at least 76 bus clocks.
// [R2] The low pulse on clock_well_reset_n is measured in whole bus clocks and that count picks the mode.
// [R3] A low pulse of 4, 5, 6 or 7 bus clocks selects xor chain mode 1, 2, 3 or 4.
// [R4] A low pulse of exactly 8 bus clocks selects the all outputs tri-state mode.
// [R5] The tester never holds the pin low for 9 to 42 bus clocks, a reserved range.
// [R6] A low pulse under 4 or over 42 bus clocks leaves normal operation with no test mode.
// [R7] The tester may start the low pulse any time after bus_reset_out is inactive.
// [R8] The pin is synchronised, low cycles are counted while asserted, and decoded on return high.
package test_mode_pkg;

  // Bus clock period and core clock period, in ps
  localparam int unsigned BUS_CLK_PERIOD_PS  = 30303;
  localparam int unsigned CORE_CLK_PERIOD_PS = 5000;
  // Core cycles per bus clock, rounded to nearest (6)
  localparam int unsigned BUS_DIV_CYCLES =
    (BUS_CLK_PERIOD_PS + CORE_CLK_PERIOD_PS / 2) / CORE_CLK_PERIOD_PS;

  // Counts in bus clocks
  localparam logic [6:0] PWR_GOOD_MIN_CLKS = 7'h4C;  // 76
  localparam logic [5:0] XOR_FIRST_CLKS    = 6'h04;
  localparam logic [5:0] XOR_LAST_CLKS     = 6'h07;
  localparam logic [5:0] TRISTATE_CLKS     = 6'h08;
  localparam logic [5:0] RESERVED_LAST     = 6'h2A;  // 42
  localparam logic [5:0] LOW_CNT_MAX       = 6'h3F;  // Saturation point

  typedef enum logic [2:0] {
    MODE_NONE,
    MODE_XOR1,
    MODE_XOR2,
    MODE_XOR3,
    MODE_XOR4,
    MODE_TRISTATE,
    MODE_RESERVED
  } test_mode_t;

  // Decoded mode outputs grouped together
  typedef struct packed {
    test_mode_t mode;
    logic [3:0] xor_chain_en;
    logic       tristate_all;
    logic       reserved_hit;
  } mode_out_t;

endpackage : test_mode_pkg

// ---- core/test_mode_selector.sv ----
`timescale 1ns/1ps
module test_mode_selector (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   reset_i,
  // Board pins
  input  wire logic                   power_good_i,
  input  wire logic                   bus_reset_out_i,
  input  wire logic                   clock_well_reset_n_i,
  // Selected mode and arming flag
  output test_mode_pkg::mode_out_t    mode_o,
  output logic                        armed_o
);

  localparam logic [2:0] DIV_LAST = 3'(test_mode_pkg::BUS_DIV_CYCLES - 1);

  typedef enum logic [1:0] {ST_WAIT_PWR, ST_IDLE, ST_LOW} sel_state_t;

  typedef struct packed {
    logic [1:0]                pin_sync;
    logic [2:0]                div;
    logic [6:0]                pwr_cnt;
    logic [5:0]                low_cnt;
    sel_state_t                state;
    test_mode_pkg::mode_out_t  out;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic   bus_tick;
  logic   pin_low;
  logic   decode_tick;
  logic   count_tick;

  // Bus clock enable from divider; pin level from second sync stage only
  assign bus_tick = (state_reg.div == DIV_LAST);
  assign pin_low  = ~state_reg.pin_sync[1];

  // Next state
  always_comb begin
    state_next          = state_reg;
    state_next.pin_sync = {state_reg.pin_sync[0], clock_well_reset_n_i};  // [R8]
    state_next.div      = bus_tick ? 3'h0 : state_reg.div + 3'h1;
    if (!power_good_i) begin
      // Power loss drops back to waiting, selection is lost
      state_next.pwr_cnt = 7'h00;
      state_next.low_cnt = 6'h00;
      state_next.state   = ST_WAIT_PWR;
      state_next.out     = '0;
    end else if (bus_tick) begin
      unique case (state_reg.state)
        ST_WAIT_PWR: begin
          if (state_reg.pwr_cnt != test_mode_pkg::PWR_GOOD_MIN_CLKS)
            state_next.pwr_cnt = state_reg.pwr_cnt + 7'h01;
          // Pulse before bus reset release is not the tester's, ignore it
          if (state_reg.pwr_cnt == test_mode_pkg::PWR_GOOD_MIN_CLKS && !bus_reset_out_i)  // [R1] [R7]
            state_next.state = ST_IDLE;
        end
        ST_IDLE: begin
          // Idle high between pulses; the first low tick opens a count
          if (pin_low) begin
            state_next.low_cnt = 6'h01;  // [R2]
            state_next.state   = ST_LOW;
          end
        end
        ST_LOW: begin
          if (pin_low) begin
            if (state_reg.low_cnt != test_mode_pkg::LOW_CNT_MAX)  // Saturate, long pulses stay long
              state_next.low_cnt = state_reg.low_cnt + 6'h01;  // [R2]
          end else begin
            // Pin back high: decode the finished count
            state_next.state = ST_IDLE;
            state_next.out   = '0;
            if (state_reg.low_cnt >= test_mode_pkg::XOR_FIRST_CLKS &&
                state_reg.low_cnt <= test_mode_pkg::XOR_LAST_CLKS) begin  // [R3]
              state_next.out.mode = test_mode_pkg::test_mode_t'(3'(state_reg.low_cnt) - 3'h3);
              state_next.out.xor_chain_en =
                4'h1 << 2'(state_reg.low_cnt - test_mode_pkg::XOR_FIRST_CLKS);
            end else if (state_reg.low_cnt == test_mode_pkg::TRISTATE_CLKS) begin  // [R4]
              state_next.out.mode         = test_mode_pkg::MODE_TRISTATE;
              state_next.out.tristate_all = 1'b1;
            end else if (state_reg.low_cnt > test_mode_pkg::TRISTATE_CLKS &&
                         state_reg.low_cnt <= test_mode_pkg::RESERVED_LAST) begin  // [R5]
              // Undefined range: flag it, select nothing
              state_next.out.mode         = test_mode_pkg::MODE_RESERVED;
              state_next.out.reserved_hit = 1'b1;
            end
            // Otherwise normal operation  [R6]
          end
        end
        default: state_next.state = ST_WAIT_PWR;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      // Sync stages start at the pin's idle high, so no false low after reset
      state_reg          <= '0;
      state_reg.pin_sync <= 2'h3;
    end else begin
      state_reg <= state_next;
    end
  end

  assign mode_o  = state_reg.out;
  assign armed_o = (state_reg.state != ST_WAIT_PWR);

  // Decode and count ticks, shared by the checks below
  assign decode_tick = (state_reg.state == ST_LOW) && bus_tick && !pin_low && power_good_i;
  assign count_tick  = (state_reg.state == ST_LOW) && bus_tick && pin_low && power_good_i;

  // No arming before the power good count has run
  a_arm_after_pwr: assert property (@(posedge clk_i) disable iff (reset_i)  // [R1]
    $rose(armed_o) |-> $past(state_reg.pwr_cnt) == test_mode_pkg::PWR_GOOD_MIN_CLKS && power_good_i)
    else $error("armed before power good count ran");

  // Tristate only after an eight count
  a_tristate_cnt: assert property (@(posedge clk_i) disable iff (reset_i)  // [R4]
    $rose(mode_o.tristate_all) |-> $past(state_reg.low_cnt) == test_mode_pkg::TRISTATE_CLKS)
    else $error("tristate mode without count of 8");

  // Xor chain enables one-hot, never with tristate
  a_xor_onehot: assert property (@(posedge clk_i) disable iff (reset_i)  // [R3]
    mode_o.xor_chain_en != 4'h0 |-> $onehot(mode_o.xor_chain_en) && !mode_o.tristate_all)
    else $error("xor chain enables not one-hot");

  // Short or long pulse gives no mode
  a_no_mode_out: assert property (@(posedge clk_i) disable iff (reset_i)  // [R6]
    state_reg.state == ST_LOW && bus_tick && !pin_low &&
    (state_reg.low_cnt < test_mode_pkg::XOR_FIRST_CLKS || state_reg.low_cnt > test_mode_pkg::RESERVED_LAST)
    |=> mode_o == '0)
    else $error("mode selected for out of range pulse");

  // Counter steps only on bus ticks while low
  a_low_count: assert property (@(posedge clk_i) disable iff (reset_i)  // [R2]
    state_reg.state == ST_LOW && !bus_tick && power_good_i |=> $stable(state_reg.low_cnt))
    else $error("low count moved off a bus tick");

  // Bus tick spacing is the divider period
  a_tick_period: assert property (@(posedge clk_i) disable iff (reset_i)  // [R2]
    bus_tick |=> !bus_tick [*5] ##1 bus_tick)
    else $error("bus tick period wrong");

  // Decode only when pin returns high
  a_decode_on_high: assert property (@(posedge clk_i) disable iff (reset_i)  // [R8]
    $changed(mode_o) && power_good_i |-> $past(state_reg.state) == ST_LOW && $past(state_reg.pin_sync[1]))
    else $error("mode changed without pin release");

  // Reserved flag comes with no chain and no tri-state
  a_reserved_flag: assert property (@(posedge clk_i) disable iff (reset_i)  // [R5]
    mode_o.reserved_hit |-> mode_o.xor_chain_en == 4'h0 && !mode_o.tristate_all)
    else $error("reserved range selected a mode");

  // Power loss drops the selection and the arming on the next clock
  a_pwr_loss_clear: assert property (@(posedge clk_i) disable iff (reset_i)  // [R1]
    !power_good_i |=> mode_o == '0 && !armed_o)
    else $error("selection survived power loss");

  // Nothing is selected while still waiting for power good
  a_wait_no_mode: assert property (@(posedge clk_i) disable iff (reset_i)  // [R1]
    !armed_o |-> mode_o == '0)
    else $error("mode selected before arming");

  // Once armed, stays armed while power good holds
  a_arm_holds: assert property (@(posedge clk_i) disable iff (reset_i)  // [R1]
    armed_o && power_good_i |=> armed_o)
    else $error("arming lost with power good high");

  // Armed states are only ever reached with the full power good count
  a_arm_count: assert property (@(posedge clk_i) disable iff (reset_i)  // [R1]
    armed_o |-> state_reg.pwr_cnt == test_mode_pkg::PWR_GOOD_MIN_CLKS)
    else $error("armed without full power good count");

  // Arming only follows a sample of the bus reset output inactive
  a_bus_reset_gate: assert property (@(posedge clk_i) disable iff (reset_i)  // [R7]
    $rose(armed_o) |-> !$past(bus_reset_out_i))
    else $error("armed while bus reset output active");

  // Pin level used by the counter is the input two clocks back
  a_sync_lag: assert property (@(posedge clk_i) disable iff (reset_i)  // [R8]
    pin_low |-> !$past(clock_well_reset_n_i, 2))
    else $error("pin level not from second sync stage");

  // First low tick starts the count at one
  a_count_start: assert property (@(posedge clk_i) disable iff (reset_i)  // [R2]
    state_reg.state == ST_IDLE && bus_tick && pin_low && power_good_i
    |=> state_reg.state == ST_LOW && state_reg.low_cnt == 6'h01)
    else $error("low count did not start at one");

  // Each further low tick adds one until the count saturates
  a_count_step: assert property (@(posedge clk_i) disable iff (reset_i)  // [R2]
    count_tick && state_reg.low_cnt != test_mode_pkg::LOW_CNT_MAX
    |=> state_reg.low_cnt == $past(state_reg.low_cnt) + 6'h01)
    else $error("low count missed a tick");

  // A saturated count stays put, so a very long pulse still reads as long
  a_count_sat: assert property (@(posedge clk_i) disable iff (reset_i)  // [R6]
    count_tick && state_reg.low_cnt == test_mode_pkg::LOW_CNT_MAX
    |=> state_reg.low_cnt == test_mode_pkg::LOW_CNT_MAX)
    else $error("saturated low count wrapped");

  // Four ticks low picks the first chain, seven the last
  a_xor_first: assert property (@(posedge clk_i) disable iff (reset_i)  // [R3]
    decode_tick && state_reg.low_cnt == test_mode_pkg::XOR_FIRST_CLKS
    |=> mode_o.mode == test_mode_pkg::MODE_XOR1 && mode_o.xor_chain_en == 4'h1)
    else $error("count of 4 did not pick chain 1");

  a_xor_last: assert property (@(posedge clk_i) disable iff (reset_i)  // [R3]
    decode_tick && state_reg.low_cnt == test_mode_pkg::XOR_LAST_CLKS
    |=> mode_o.mode == test_mode_pkg::MODE_XOR4 && mode_o.xor_chain_en == 4'h8)
    else $error("count of 7 did not pick chain 4");

  // Eight ticks low gives the tri-state mode with no chain enabled
  a_tristate_sel: assert property (@(posedge clk_i) disable iff (reset_i)  // [R4]
    decode_tick && state_reg.low_cnt == test_mode_pkg::TRISTATE_CLKS
    |=> mode_o.mode == test_mode_pkg::MODE_TRISTATE && mode_o.tristate_all && mode_o.xor_chain_en == 4'h0)
    else $error("count of 8 did not pick tri-state");

  // Selection holds between decodes while power good stays high
  a_mode_holds: assert property (@(posedge clk_i) disable iff (reset_i)  // [R8]
    power_good_i && !decode_tick |=> $stable(mode_o))
    else $error("mode changed without a decode");

endmodule : test_mode_selector

// ---- testbench/board_tester.sv ----
`timescale 1ns/1ps
// Board tester model driving the test reset pin
module board_tester (
  // Clock and pin
  input  wire logic clk_i,
  output logic      pin_n_o
);
  initial pin_n_o = 1'b1;
  // Low for n bus clocks, then a quiet gap so decode lands first
  task automatic pulse(input int n);
    @(posedge clk_i);
    pin_n_o <= 1'b0;
    repeat (n * test_mode_pkg::BUS_DIV_CYCLES) @(posedge clk_i);
    pin_n_o <= 1'b1;
    repeat (24) @(posedge clk_i);
  endtask : pulse
endmodule : board_tester

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic                     clk_i, reset_i, power_good_i, bus_reset_out_i, armed_o, pin_n;
  test_mode_pkg::mode_out_t mode_o, seen, last_exp, e2, exp_q[$];
  int                       miscompares, total_checks, cycles;
  logic [31:0]              lfsr = 32'h0000_fb2a;
  int                       counts[10] = '{4, 5, 6, 7, 8, 3, 1, 8, 70, 43};

  test_mode_selector uut (.clk_i(clk_i), .reset_i(reset_i), .power_good_i(power_good_i),
    .bus_reset_out_i(bus_reset_out_i), .clock_well_reset_n_i(pin_n), .mode_o(mode_o), .armed_o(armed_o));
  board_tester tester (.clk_i(clk_i), .pin_n_o(pin_n));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Expected mode for a pulse of n bus clocks
  function automatic test_mode_pkg::mode_out_t expect_of(input int n);
    test_mode_pkg::mode_out_t e;
    e = '0;
    if (n >= 4 && n <= 7) begin
      e.mode = test_mode_pkg::test_mode_t'(n - 3);
      e.xor_chain_en = 4'h1 << (n - 4);
    end else if (n == 8) begin
      e.mode = test_mode_pkg::MODE_TRISTATE;
      e.tristate_all = 1'b1;
    end else if (n >= 9 && n <= 42) begin
      e.mode = test_mode_pkg::MODE_RESERVED;
      e.reserved_hit = 1'b1;
    end
    return e;
  endfunction : expect_of

  // Galois shift register step
  function automatic logic [31:0] next_rand(input logic [31:0] l);
    return {l[30:0], 1'b0} ^ (l[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction : next_rand

  task automatic note(input test_mode_pkg::mode_out_t e);
    if (e !== last_exp) exp_q.push_back(e);
    last_exp = e;
  endtask : note

  task automatic run(input int n);
    note(expect_of(n));
    tester.pulse(n);
    $display("pulse of %0d bus clocks done", n);
  endtask : run

  task automatic chk(input logic ok, input string what);
    total_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("MISMATCH %s expected 1 seen %b", what, ok);
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report

  // Watcher: every change of mode_o consumes the oldest note
  always @(negedge clk_i) begin
    if (!reset_i && mode_o !== seen) begin
      seen = mode_o;
      total_checks++;
      e2 = (exp_q.size() > 0) ? exp_q.pop_front() : ~mode_o;
      if (e2 !== mode_o) begin
        miscompares++;
        $display("MISMATCH mode_o expected %h seen %h", e2, mode_o);
      end
    end
  end

  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 10000) begin
      miscompares++;
      final_report();
    end
  end

  initial begin
    reset_i = 1'b1; power_good_i = 1'b1; bus_reset_out_i = 1'b1; seen = '0; last_exp = '0;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    tester.pulse(4); // Too early, must be ignored
    repeat (300) @(posedge clk_i);
    chk(armed_o === 1'b0, "armed_o early");
    bus_reset_out_i <= 1'b0;
    for (int i = 0; i < 600 && armed_o !== 1'b1; i++) @(posedge clk_i);
    chk(armed_o === 1'b1, "armed_o");
    foreach (counts[i]) run(counts[i]);
    for (int i = 0; i < 20; i++) begin
      lfsr = next_rand(lfsr);
      run(1 + int'(lfsr[2:0])); // Random stays below the reserved range
    end
    run(8);
    power_good_i <= 1'b0; // Power loss clears the selection
    note('0);
    repeat (20) @(posedge clk_i);
    chk(exp_q.size() == 0, "all results seen");
    final_report();
  end
endmodule : tb
